// [hw/qpg_pwm.sv]
`timescale 1ns/100ps
module qpg_pwm (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic paddrValid,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chipSel_n,
   input wire logic write_n,
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic global_float_ctl,
   input wire logic devReset_n,
   output logic [3:0] pwmOut,
   output logic [3:0] pwmOutEn
);
   logic [31:0] ctrl_r;
   logic stepDiv_r;
   logic stepEn;
   logic [7:0] stepCnt_r;
   logic [3:0] subCnt_r;
   logic cycleEnd;
   logic sclkPrev_r;
   logic wrPrev_r;
   logic [7:0] shift_r;
   logic [7:0] lower_r;
   logic [7:0] upper_r;
   logic upperPending_r;
   logic loadPulse;
   logic [11:0] loadValue;
   logic [1:0] loadChan;
   logic loadEnable;
   logic [11:0] pwmReg_r [4];
   logic [3:0] enReg_r;
   logic [11:0] active_r [4];
   logic [3:0] activeEn_r;
   logic floatAll_r;
   logic resetHold_r;
   logic [3:0] lengthened_subsection;
   logic run;

   assign run = ctrl_r[qpg_pkg::CTRL_RUN];

   // APB slave, zero wait states
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr == qpg_pkg::OFF_CTRL
      || paddr == qpg_pkg::OFF_STATUS
      || (paddr >= qpg_pkg::OFF_PWM0 && paddr < qpg_pkg::OFF_PWM0 + 12'h010));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= qpg_pkg::CTRL_RESET;
      end else if (psel && penable && pwrite && paddr == qpg_pkg::OFF_CTRL) begin
         ctrl_r <= {31'h0000_0000, pwdata[qpg_pkg::CTRL_RUN]};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == qpg_pkg::OFF_CTRL) begin
            prdata <= ctrl_r;
         end else if (paddr == qpg_pkg::OFF_STATUS) begin
            prdata <= {16'h0000, 4'h0, subCnt_r, activeEn_r, 2'b00,
               resetHold_r, floatAll_r};
         end else if (paddr >= qpg_pkg::OFF_PWM0
            && paddr < qpg_pkg::OFF_PWM0 + 12'h010) begin
            prdata <= {20'h00000, pwmReg_r[paddr[3:2]]};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Step enable at half the clock rate
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stepDiv_r <= 1'b0;
      end else if (run) begin
         stepDiv_r <= !stepDiv_r;
      end
   end
   assign stepEn = run && stepDiv_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stepCnt_r <= 8'h00;
         subCnt_r <= 4'h0;
      end else if (resetHold_r && !devReset_n) begin
         stepCnt_r <= 8'h00;
         subCnt_r <= 4'h0;
      end else if (stepEn) begin
         stepCnt_r <= stepCnt_r + 8'h01;
         if (stepCnt_r == 8'hFF) begin
            subCnt_r <= subCnt_r + 4'h1;
         end
      end
   end
   assign cycleEnd = stepEn && stepCnt_r == 8'hFF && subCnt_r == 4'hF;

   // Serial port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sclkPrev_r <= 1'b0;
         wrPrev_r <= 1'b1;
         shift_r <= 8'h00;
      end else begin
         sclkPrev_r <= serialClk;
         wrPrev_r <= write_n;
         if (!chipSel_n && !write_n && serialClk && !sclkPrev_r) begin
            shift_r <= {shift_r[6:0], serialData};
         end
      end
   end

   always_comb begin
      loadPulse = 1'b0;
      loadValue = {upper_r, lower_r[qpg_pkg::LB_DATA_HI:qpg_pkg::LB_DATA_LO]};
      loadChan = lower_r[qpg_pkg::LB_CHAN_HI:qpg_pkg::LB_CHAN_LO];
      loadEnable = lower_r[qpg_pkg::LB_ENABLE];
      if (write_n && !wrPrev_r && !chipSel_n) begin
         if (upperPending_r) begin
            loadPulse = 1'b1;
            loadValue = {shift_r, lower_r[qpg_pkg::LB_DATA_HI:qpg_pkg::LB_DATA_LO]};
         end else if (!shift_r[qpg_pkg::LB_UPPER_FOLLOWS]
            || !shift_r[qpg_pkg::LB_ENABLE]) begin
            loadPulse = 1'b1;
            loadValue = {upper_r, shift_r[qpg_pkg::LB_DATA_HI:qpg_pkg::LB_DATA_LO]};
            loadChan = shift_r[qpg_pkg::LB_CHAN_HI:qpg_pkg::LB_CHAN_LO];
            loadEnable = shift_r[qpg_pkg::LB_ENABLE];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lower_r <= 8'h00;
         upper_r <= 8'h00;
         upperPending_r <= 1'b0;
      end else if (write_n && !wrPrev_r && !chipSel_n) begin
         if (upperPending_r) begin
            upper_r <= shift_r;
            upperPending_r <= 1'b0;
         end else begin
            lower_r <= {shift_r[7:1], shift_r[0] && shift_r[qpg_pkg::LB_ENABLE]};
            upperPending_r <= shift_r[0] && shift_r[qpg_pkg::LB_ENABLE];
         end
      end
   end

   // Reset pin acts at cycle end, held while low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         resetHold_r <= 1'b0;
      end else begin
         if (!devReset_n && cycleEnd) begin
            resetHold_r <= 1'b1;
         end else if (devReset_n) begin
            resetHold_r <= 1'b0;
         end
      end
   end

   generate
      for (genvar ch = 0; ch < qpg_pkg::CHANNELS; ch++) begin : gChan
         logic [11:0] stepVal;
         // First step of a new cycle already uses the value taken at its start
         assign stepVal = cycleEnd ? (devReset_n ? pwmReg_r[ch] : qpg_pkg::PWM_RESET)
            : active_r[ch];
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               pwmReg_r[ch] <= qpg_pkg::PWM_RESET;
               enReg_r[ch] <= 1'b0;
            end else if ((!devReset_n && cycleEnd) || resetHold_r) begin
               pwmReg_r[ch] <= qpg_pkg::PWM_RESET;
               enReg_r[ch] <= 1'b0;
            end else if (loadPulse && loadChan == 2'(ch)) begin
               enReg_r[ch] <= loadEnable;
               if (loadEnable) begin
                  pwmReg_r[ch] <= loadValue;
               end
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               active_r[ch] <= qpg_pkg::PWM_RESET;
               activeEn_r[ch] <= 1'b0;
            end else if (cycleEnd) begin
               active_r[ch] <= stepVal;
               activeEn_r[ch] <= devReset_n && enReg_r[ch];
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               pwmOut[ch] <= 1'b0;
            end else if (stepEn) begin
               // High for basic width plus optional step from subsection start
               pwmOut[ch] <= ({1'b0, stepStart(stepCnt_r)}
                  < {1'b0, stepVal[11:4]}
                  + {8'h00, lengthMask(stepVal[3:0], nextSub(stepCnt_r, subCnt_r))});
            end
         end
         // Flag for the subsection now running
         assign lengthened_subsection[ch] = lengthMask(active_r[ch][3:0], subCnt_r);
         assign pwmOutEn[ch] = activeEn_r[ch] && !floatAll_r && !resetHold_r;
      end
   endgenerate

   function automatic logic [7:0] stepStart(input logic [7:0] s);
      stepStart = s + 8'h01;
   endfunction

   function automatic logic [3:0] nextSub(input logic [7:0] s, input logic [3:0] u);
      nextSub = (s == 8'hFF) ? u + 4'h1 : u;
   endfunction

   // Rate multiplier: never subsection 0, so step 255 of sub 0 stays low
   function automatic logic lengthMask(input logic [3:0] low, input logic [3:0] m);
      lengthMask = (low[0] && m == 4'h8)
         || (low[1] && m[2:0] == 3'b100)
         || (low[2] && m[1:0] == 2'b10)
         || (low[3] && m[0]);
   endfunction

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         floatAll_r <= 1'b1;
      end else if (cycleEnd) begin
         floatAll_r <= global_float_ctl;
      end
   end

   // Cycle timing, loading and float checks
   chk_full_high_never: assert property (@(posedge clk) disable iff (!arst_n)
      (stepEn && subCnt_r == 4'h0 && stepCnt_r == 8'hFE) |=> pwmOut == 4'h0)
      else $error("output high through a whole cycle");
   chk_float_on_ctl: assert property (@(posedge clk) disable iff (!arst_n)
      (cycleEnd && global_float_ctl) |=> pwmOutEn == 4'h0)
      else $error("outputs driven while float control high");
   chk_value_at_boundary: assert property (@(posedge clk) disable iff (!arst_n)
      !cycleEnd |=> $stable(active_r[1]))
      else $error("active value changed mid cycle");
   chk_reset_clears: assert property (@(posedge clk) disable iff (!arst_n)
      (cycleEnd && !devReset_n) |=> (pwmReg_r[2] == 12'h000 && pwmOutEn == 4'h0))
      else $error("device reset did not clear");
   chk_step_rate: assert property (@(posedge clk) disable iff (!arst_n)
      stepEn |=> !stepEn)
      else $error("step enable faster than half rate");
   chk_disable_no_upper: assert property (@(posedge clk) disable iff (!arst_n)
      (write_n && !wrPrev_r && !chipSel_n && !upperPending_r && !shift_r[3])
      |=> !upperPending_r)
      else $error("upper byte expected after disable");
   chk_no_zero_lengthen: assert property (@(posedge clk) disable iff (!arst_n)
      subCnt_r == 4'h0 |-> lengthened_subsection == 4'h0)
      else $error("subsection zero lengthened");
   chk_cycle_wrap: assert property (@(posedge clk) disable iff (!arst_n)
      cycleEnd |=> (subCnt_r == 4'h0 && stepCnt_r == 8'h00))
      else $error("cycle did not wrap after 4096 steps");
   chk_enable_at_boundary: assert property (@(posedge clk) disable iff (!arst_n)
      !cycleEnd |=> $stable(activeEn_r))
      else $error("output enable changed mid cycle");
   chk_hold_counter: assert property (@(posedge clk) disable iff (!arst_n)
      (resetHold_r && !devReset_n) |=> (stepCnt_r == 8'h00 && subCnt_r == 4'h0))
      else $error("cycle counter ran during device reset");
   chk_float_keeps_value: assert property (@(posedge clk) disable iff (!arst_n)
      (!loadPulse && devReset_n && !resetHold_r) |=> $stable(pwmReg_r[0]))
      else $error("value changed without a write");
   chk_first_step_new: assert property (@(posedge clk) disable iff (!arst_n)
      cycleEnd |=> pwmOut[0] == (active_r[0][11:4] != 8'h00))
      else $error("first step of a cycle used the old value");
endmodule

// [inc/qpg_pkg.sv]
package qpg_pkg;
   localparam int CHANNELS = 4;
   localparam int DATA_W = 12;
   localparam int BYTE_W = 8;
   localparam int SUBSECTIONS = 16;
   localparam int STEPS_PER_SUB = 256;
   // Oscillator periods per minimum step
   localparam int OSC_PER_STEP = 2;
   localparam logic [11:0] PWM_RESET = 12'h000;
   // Lower byte field positions
   localparam int LB_DATA_HI = 7;
   localparam int LB_DATA_LO = 4;
   localparam int LB_ENABLE = 3;
   localparam int LB_CHAN_HI = 2;
   localparam int LB_CHAN_LO = 1;
   localparam int LB_UPPER_FOLLOWS = 0;
   // APB register offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_PWM0 = 12'h010;
   localparam int CTRL_RUN = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
endpackage

// [verif/qpg_host_model.sv]
`timescale 1ns/100ps
module qpg_host_model (
   input wire logic clk,
   output logic chipSel_n = 1'b1,
   output logic write_n = 1'b1,
   output logic serialClk = 1'b0,
   output logic serialData = 1'b0
);
   task automatic gap();
      repeat (4) @(posedge clk);
   endtask
   // One framed byte, shift clock idle low outside frames
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk);
      chipSel_n <= 1'b0;
      write_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         gap();
         serialData <= b[i];
         gap();
         serialClk <= 1'b1;
         gap();
         serialClk <= 1'b0;
      end
      gap();
      write_n <= 1'b1;
      gap();
      chipSel_n <= 1'b1;
      serialData <= ~b[0];
   endtask
   task automatic write_chan(input logic [1:0] ch, input logic [11:0] v, input logic en);
      send_byte({v[3:0], en, ch, en});
      if (en) send_byte(v[11:4]);
   endtask
endmodule

// [verif/quad_serial_pwm_generator_bench.sv]
`timescale 1ns/100ps
module quad_serial_pwm_generator_bench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, chipSel_n, write_n, serialClk, serialData, er, p;
   logic floatCtl = 1'b0;
   logic devReset_n = 1'b1;
   logic [3:0] pwmOut, pwmOutEn;
   logic [11:0] val [4];
   logic [31:0] rd;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int cnt [4][16];
   always #20 clk = ~clk;
   qpg_pwm u_dut (.clk(clk), .arst_n(arst_n), .paddrValid(1'b0), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chipSel_n(chipSel_n), .write_n(write_n),
      .serialClk(serialClk), .serialData(serialData), .global_float_ctl(floatCtl),
      .devReset_n(devReset_n), .pwmOut(pwmOut), .pwmOutEn(pwmOutEn));
   qpg_host_model u_host (.clk(clk), .chipSel_n(chipSel_n), .write_n(write_n),
      .serialClk(serialClk), .serialData(serialData));
   task automatic chk(input bit ok, input string m);
      cmp_count++;
      if (!ok) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 70000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_pwm(input int c);
      apb(1'b0, 12'(qpg_pkg::OFF_PWM0 + 4 * c), 32'h0);
   endtask
   // Polls the subsection index up to the next cycle start
   task automatic wait_sub0();
      int n = 0;
      do apb(1'b0, qpg_pkg::OFF_STATUS, 32'h0); while (rd[11:8] !== 4'hF && ++n < 4000);
      do apb(1'b0, qpg_pkg::OFF_STATUS, 32'h0); while (rd[11:8] !== 4'h0 && ++n < 8000);
      repeat (4) @(posedge clk);
   endtask
   function automatic int expw(input logic [11:0] v, input int m);
      bit x;
      x = (m == 8 && v[0]) || (m % 8 == 4 && v[1]) || (m % 4 == 2 && v[2]) || (m % 2 && v[3]);
      return 2 * (int'(v[11:4]) + int'(x));
   endfunction
   initial begin
      void'($urandom(99));
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk(pwmOutEn === 4'h0, "float after reset");
      apb(1'b0, qpg_pkg::OFF_CTRL, 32'h0);
      chk(rd === qpg_pkg::CTRL_RESET && er === 1'b0, "ctrl reset value");
      apb(1'b0, 12'h008, 32'h0);
      chk(er === 1'b1 && rd === 32'h0000_0000, "unmapped read");
      $display("test registers done");
      u_host.send_byte(8'h00);
      val[0] = {8'($urandom_range(254, 1)), 4'($urandom)};
      val[1] = {8'($urandom), 4'h0};
      val[2] = 12'hFFF;
      val[3] = 12'h001;
      for (int c = 0; c < 4; c++) begin
         u_host.write_chan(2'(c), val[c], 1'b1);
         rd_pwm(c);
         chk(rd === {20'h0, val[c]}, "value readback");
      end
      apb(1'b1, qpg_pkg::OFF_PWM0, $urandom);
      rd_pwm(0);
      chk(rd === {20'h0, val[0]}, "read-only value written");
      for (int n = 0; n < 9000 && pwmOutEn !== 4'hF; n++) @(posedge clk);
      chk(pwmOutEn === 4'hF, "outputs enabled");
      // Full-scale channel rises only at subsection 1
      p = 1'b1;
      for (int n = 0; n < 9000; n++) begin
         @(posedge clk);
         if (p === 1'b0 && pwmOut[2] === 1'b1) break;
         p = pwmOut[2];
      end
      cnt = '{default: 0};
      for (int i = 0; i < 8192; i++) begin
         for (int c = 0; c < 4; c++) cnt[c][(i / 512 + 1) % 16] += int'(pwmOut[c] === 1'b1);
         @(posedge clk);
      end
      for (int c = 0; c < 4; c++)
         for (int m = 0; m < 16; m++)
            chk(cnt[c][m] == expw(val[c], m), $sformatf("width ch%0d sub%0d", c, m));
      $display("test waveform done");
      floatCtl <= 1'b1;
      u_host.write_chan(2'd3, 12'h000, 1'b0);
      chk(pwmOutEn === 4'hF, "float before cycle end");
      wait_sub0();
      chk(pwmOutEn === 4'h0, "global float");
      floatCtl <= 1'b0;
      u_host.write_chan(2'd1, 12'h5A3, 1'b1);
      rd_pwm(1);
      chk(rd === 32'h0000_05A3, "write while floated");
      wait_sub0();
      chk(pwmOutEn === 4'h7, "channel disable");
      rd_pwm(3);
      chk(rd === 32'h0000_0001, "disable keeps value");
      $display("test float done");
      devReset_n <= 1'b0;
      rd_pwm(0);
      chk(rd === {20'h0, val[0]}, "reset before cycle end");
      repeat (8300) @(posedge clk);
      chk(pwmOutEn === 4'h0, "reset floats");
      for (int c = 0; c < 4; c++) begin
         rd_pwm(c);
         chk(rd === 32'h0000_0000, "reset clears value");
      end
      devReset_n <= 1'b1;
      u_host.write_chan(2'd0, val[0], 1'b1);
      wait_sub0();
      chk(pwmOutEn === 4'h1, "only rewritten channel drives");
      $display("test device reset done");
      wrap_up();
   end
endmodule
